/* core/fbsmc_pkg.sv */
// Package of constants and carrier types for the station mode controller
package fbsmc_pkg;
    // Operating modes, explicit binary codes
    typedef enum logic [1:0] {
        FBSMC_IDLE  = 2'h0,
        FBSMC_READY = 2'h1,
        FBSMC_RUN   = 2'h2
    } fbsmc_mode_e;

    // Network mode commands
    typedef enum logic [1:0] {
        FBSMC_CMD_IDLE  = 2'h0,
        FBSMC_CMD_READY = 2'h1,
        FBSMC_CMD_RUN   = 2'h2
    } fbsmc_cmd_e;

    localparam int CLK_HZ = 25000000;            // System clock rate
    localparam int COMM_TIMEOUT_MS = 100;        // Default comm loss timeout
    localparam int COMM_TIMEOUT_CYC = CLK_HZ / 1000 * COMM_TIMEOUT_MS; // Rounded down
    localparam int DIAG_MS = 200;                // Power-up diagnostics time
    localparam int DIAG_CYC = CLK_HZ / 1000 * DIAG_MS;
    localparam int BLINK_MS = 10;                // Health blink half period
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam logic VAL_INVALID = 1'b1;         // Validity qualifier: invalid
    localparam logic VAL_VALID = 1'b0;           // Validity qualifier: valid
    localparam int NCH = 2;                      // Bus channels

    // One output word with its qualifier, travels through the buffer
    typedef struct packed {
        logic [7:0] data;                        // Output point states
        logic       qual;                        // Validity qualifier, 1 = invalid
    } fbsmc_word_s;
endpackage

/* core/fbsmc_station.sv */
// Station mode controller: mode state, output path, validators, indicators
`timescale 1ns/1ps

module fbsmc_station #(
    parameter int COMM_TO_CYC = fbsmc_pkg::COMM_TIMEOUT_CYC, // Comm loss timeout
    parameter int DIAG_CYCLES = fbsmc_pkg::DIAG_CYC,          // Diagnostics duration
    parameter int BLINK_CYCLES = fbsmc_pkg::BLINK_CYC         // Blink half period
) (
    input wire logic clk_sys,                          // 25 MHz system clock
    input wire logic sys_rst,                          // Async reset, active high
    input wire logic [1:0] net_present,                // Network seen per channel
    input wire logic [1:0] carrier_det,                // Carrier detect per channel
    input wire logic [1:0] tx_active,                  // Transmitter active per channel
    input wire logic frame_ok,                         // Valid traffic from controller
    input wire logic cmd_valid,                        // Mode command strobe
    input wire fbsmc_pkg::fbsmc_cmd_e cmd_mode,        // Commanded mode
    input wire logic cfg_valid,                        // Configuration delivered
    input wire logic cfg_enable,                       // Configuration enabled
    input wire logic net_force_req,                    // Force request via network
    input wire logic out_valid,                        // Output word from network
    input wire fbsmc_pkg::fbsmc_word_s out_word,       // Output data and qualifier
    output logic out_ready,                            // Buffer can take a word
    input wire logic [7:0] nv_default,                 // Defaults from non-volatile store
    input wire logic [7:0] nv_force_mask,              // Forced points from store
    input wire logic [7:0] nv_force_val,               // Force values from store
    input wire logic hold_last,                        // 1 = hold last, 0 = default
    output logic nv_load,                              // Reload strobe to store
    input wire logic mod_ready,                        // Output modules take a word
    input wire logic [7:0] in_data,                    // Scanned input data
    input wire logic in_fault,                         // Module or circuit fault
    output logic [7:0] mod_out,                        // Drive to output modules
    output logic mod_out_valid,                        // Word forwarded to modules
    output logic scan_en,                              // I/O scan active
    output logic [7:0] in_tx_data,                     // Inputs gathered for bus
    output logic in_qual,                              // Input qualifier
    output logic out_qual,                             // Output qualifier
    output logic io_exch_en,                           // I/O data exchange allowed
    output logic presence_en,                          // Presence announcement allowed
    output logic handheld_mon_en,                      // Handheld monitoring allowed
    output logic force_reject,                         // Network force refused pulse
    output logic fault_status,                         // Fault flag in periodic status
    output logic cfg_held,                             // Configuration held
    output fbsmc_pkg::fbsmc_mode_e mode,               // Current mode
    output logic led_ok,                               // Health indicator
    output logic led_run,                              // Run indicator
    output logic [1:0] led_carrier,                    // Carrier indicators
    output logic [1:0] led_tx                          // Transmit indicators
);
    fbsmc_pkg::fbsmc_mode_e mode_reg, mode_next;       // Mode state
    logic [31:0] to_cnt_reg;                           // Silence counter
    logic comm_lost;                                   // Timeout reached
    logic cfg_reg;                                     // Config received
    logic [7:0] def_reg, fmask_reg, fval_reg;          // Reloaded settings
    logic [7:0] last_reg;                              // Last applied outputs
    fbsmc_pkg::fbsmc_word_s buf_reg [2];               // Two-entry buffer
    logic [1:0] cnt_reg;                               // Buffer occupancy
    logic wr_ptr_reg, rd_ptr_reg;                      // Buffer pointers
    logic [31:0] diag_cnt_reg, blink_cnt_reg;          // Health timers
    logic diag_done_reg, blink_reg;                    // Health state
    logic push, pop, buf_empty;                        // Buffer handshake terms

    // Either channel counts as network presence, so one medium on any connector works
    wire net_any = |net_present;

    // Controller traffic on frame_ok restarts the timer; held at zero outside Run
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            to_cnt_reg <= 32'h0;
        end else if (frame_ok || mode_reg != fbsmc_pkg::FBSMC_RUN) begin
            to_cnt_reg <= 32'h0;
        end else if (!comm_lost) begin
            to_cnt_reg <= to_cnt_reg + 32'h1;
        end
    end
    assign comm_lost = (to_cnt_reg >= 32'(COMM_TO_CYC - 1));

    // Next mode decision
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            fbsmc_pkg::FBSMC_IDLE: begin
                // Needs network, config and a Ready command
                if (net_any && cmd_valid && cmd_mode == fbsmc_pkg::FBSMC_CMD_READY
                    && (cfg_reg || cfg_valid) && cfg_enable) begin
                    mode_next = fbsmc_pkg::FBSMC_READY;
                end
            end
            fbsmc_pkg::FBSMC_READY: begin
                if (cmd_valid && cmd_mode == fbsmc_pkg::FBSMC_CMD_IDLE) begin
                    mode_next = fbsmc_pkg::FBSMC_IDLE;
                end else if (cmd_valid && cmd_mode == fbsmc_pkg::FBSMC_CMD_RUN) begin
                    mode_next = fbsmc_pkg::FBSMC_RUN;
                end
            end
            fbsmc_pkg::FBSMC_RUN: begin
                if (comm_lost || !net_any) begin
                    mode_next = fbsmc_pkg::FBSMC_READY;
                end else if (cmd_valid && cmd_mode == fbsmc_pkg::FBSMC_CMD_READY) begin
                    mode_next = fbsmc_pkg::FBSMC_READY;
                end else if (cmd_valid && cmd_mode == fbsmc_pkg::FBSMC_CMD_IDLE) begin
                    mode_next = fbsmc_pkg::FBSMC_IDLE;
                end
            end
            default: mode_next = fbsmc_pkg::FBSMC_IDLE; // Illegal code recovers
        endcase
    end

    // Mode register, Idle after reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= fbsmc_pkg::FBSMC_IDLE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Configuration kept only from Idle; dropped on return to Idle for reconfig
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= 1'b0;
        end else if (mode_reg == fbsmc_pkg::FBSMC_IDLE && cfg_valid) begin
            cfg_reg <= 1'b1;
        end else if (mode_reg != fbsmc_pkg::FBSMC_IDLE && mode_next == fbsmc_pkg::FBSMC_IDLE) begin
            cfg_reg <= 1'b0;
        end
    end

    // Reload defaults and forces on Idle entry (and at reset release)
    wire idle_entry = (mode_next == fbsmc_pkg::FBSMC_IDLE) && (mode_reg != mode_next);
    logic first_reg;                                   // First cycle after reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            first_reg <= 1'b1;
            def_reg <= 8'h00;
            fmask_reg <= 8'h00;
            fval_reg <= 8'h00;
            nv_load <= 1'b0;
        end else begin
            first_reg <= 1'b0;
            nv_load <= idle_entry || first_reg;
            if (nv_load) begin
                def_reg <= nv_default;
                fmask_reg <= nv_force_mask;
                fval_reg <= nv_force_val;
            end
        end
    end

    // Two-entry buffer; only Run accepts network output words
    assign out_ready = (cnt_reg != 2'h2) && (mode_reg == fbsmc_pkg::FBSMC_RUN);
    assign buf_empty = (cnt_reg == 2'h0);
    assign push = out_valid && out_ready;
    assign pop = !buf_empty && mod_ready;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= 2'h0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
        end else begin
            if (push) begin
                buf_reg[wr_ptr_reg] <= out_word;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // Output drive: Run forwards valid words, otherwise default/hold then force
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mod_out <= 8'h00;
            last_reg <= 8'h00;
            mod_out_valid <= 1'b0;
            out_qual <= fbsmc_pkg::VAL_INVALID;
        end else if (mode_reg == fbsmc_pkg::FBSMC_RUN) begin
            mod_out_valid <= pop;
            if (pop && buf_reg[rd_ptr_reg].qual == fbsmc_pkg::VAL_VALID) begin
                mod_out <= buf_reg[rd_ptr_reg].data;
                last_reg <= buf_reg[rd_ptr_reg].data;
                out_qual <= fbsmc_pkg::VAL_VALID;
            end else if (pop) begin
                mod_out <= hold_last ? last_reg : def_reg;
                out_qual <= fbsmc_pkg::VAL_INVALID;
            end
        end else begin
            mod_out_valid <= 1'b0;
            mod_out <= ((hold_last ? last_reg : def_reg) & ~fmask_reg)
                       | (fval_reg & fmask_reg);
            out_qual <= (mode_reg == fbsmc_pkg::FBSMC_IDLE) ? fbsmc_pkg::VAL_INVALID
                                                        : out_qual;
        end
    end

    // Input gathering and fault reporting run in every mode
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            in_tx_data <= 8'h00;
            in_qual <= fbsmc_pkg::VAL_INVALID;
            fault_status <= 1'b0;
        end else begin
            in_tx_data <= in_data;
            fault_status <= in_fault;
            in_qual <= (mode_reg == fbsmc_pkg::FBSMC_IDLE || in_fault)
                       ? fbsmc_pkg::VAL_INVALID : fbsmc_pkg::VAL_VALID;
        end
    end

    // Enables and status from mode; scan and presence stay on in every mode
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scan_en <= 1'b0;
            io_exch_en <= 1'b0;
            presence_en <= 1'b0;
            handheld_mon_en <= 1'b0;
            force_reject <= 1'b0;
            cfg_held <= 1'b0;
            mode <= fbsmc_pkg::FBSMC_IDLE;
            led_run <= 1'b0;
        end else begin
            scan_en <= 1'b1;
            io_exch_en <= (mode_reg == fbsmc_pkg::FBSMC_RUN);
            presence_en <= 1'b1;
            handheld_mon_en <= (mode_reg == fbsmc_pkg::FBSMC_IDLE && !cfg_reg)
                              || mode_reg == fbsmc_pkg::FBSMC_READY;
            force_reject <= net_force_req && (mode_reg == fbsmc_pkg::FBSMC_IDLE);
            cfg_held <= cfg_reg;
            mode <= mode_reg;
            led_run <= (mode_reg == fbsmc_pkg::FBSMC_RUN) && push;
        end
    end

    // Channel indicators, one pair per channel
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            led_carrier <= 2'h0;
            led_tx <= 2'h0;
        end else begin
            led_carrier <= carrier_det;
            led_tx <= tx_active;
        end
    end

    // Health: blink during diagnostics then steady; blink is a slow toggle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            diag_cnt_reg <= 32'h0;
            blink_cnt_reg <= 32'h0;
            diag_done_reg <= 1'b0;
            blink_reg <= 1'b0;
            led_ok <= 1'b0;
        end else if (!diag_done_reg) begin
            diag_cnt_reg <= diag_cnt_reg + 32'h1;
            diag_done_reg <= (diag_cnt_reg >= 32'(DIAG_CYCLES - 1));
            if (blink_cnt_reg >= 32'(BLINK_CYCLES - 1)) begin
                blink_cnt_reg <= 32'h0;
                blink_reg <= ~blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 32'h1;
            end
            led_ok <= blink_reg;
        end else begin
            led_ok <= 1'b1;
        end
    end

    // Checks
    sequence s_ready_cmd;
        cmd_valid && cmd_mode == fbsmc_pkg::FBSMC_CMD_RUN && mode_reg == fbsmc_pkg::FBSMC_READY;
    endsequence
    AST_RESET_IDLE: assert property (@(posedge clk_sys) $rose(first_reg) |-> mode_reg == fbsmc_pkg::FBSMC_IDLE) else $error("not idle after reset");
    AST_NO_NET_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst) mode_reg == fbsmc_pkg::FBSMC_IDLE && !net_any |=> mode_reg == fbsmc_pkg::FBSMC_IDLE) else $error("left idle without network");
    AST_RUN_ON_CMD: assert property (@(posedge clk_sys) disable iff (sys_rst) s_ready_cmd |=> mode_reg == fbsmc_pkg::FBSMC_RUN) else $error("run command ignored");
    AST_LOSS_READY: assert property (@(posedge clk_sys) disable iff (sys_rst) mode_reg == fbsmc_pkg::FBSMC_RUN && comm_lost |=> mode_reg == fbsmc_pkg::FBSMC_READY) else $error("no fallback on loss");
    AST_IDLE_NO_EXCH: assert property (@(posedge clk_sys) disable iff (sys_rst) mode_reg == fbsmc_pkg::FBSMC_IDLE |-> !out_ready ##1 !io_exch_en) else $error("idle exchanged data");
    AST_IDLE_INVALID: assert property (@(posedge clk_sys) disable iff (sys_rst) mode_reg == fbsmc_pkg::FBSMC_IDLE |=> in_qual == fbsmc_pkg::VAL_INVALID && out_qual == fbsmc_pkg::VAL_INVALID) else $error("idle qualifier valid");
    AST_IDLE_RELOAD: assert property (@(posedge clk_sys) disable iff (sys_rst) idle_entry |=> nv_load ##1 def_reg == $past(nv_default)) else $error("no reload on idle entry");
    AST_NO_CFG_READY: assert property (@(posedge clk_sys) disable iff (sys_rst) mode_reg == fbsmc_pkg::FBSMC_IDLE && !cfg_reg && !cfg_valid |=> mode_reg == fbsmc_pkg::FBSMC_IDLE) else $error("ready without config");
    AST_CARRIER: assert property (@(posedge clk_sys) disable iff (sys_rst) ##1 led_carrier == $past(carrier_det) && led_tx == $past(tx_active)) else $error("channel indicator mismatch");
endmodule

/* sim/fbsmc_net_model.sv */
// Behavioural network controller that commands the station and streams output words
`timescale 1ns/1ps
module fbsmc_net_model (
    input wire logic clk_sys, // System clock
    input wire logic out_ready, // Station buffer can take a word
    output logic cmd_valid, // Mode command strobe
    output fbsmc_pkg::fbsmc_cmd_e cmd_mode, // Commanded mode
    output logic cfg_valid, // Configuration delivered
    output logic frame_ok, // Valid traffic seen
    output logic net_force_req, // Force request message
    output logic out_valid, // Output word offered
    output fbsmc_pkg::fbsmc_word_s out_word // Output word
);
    logic talk = 1'b0; // Controller keeps traffic going while set
    initial begin
        {cmd_valid, cfg_valid, frame_ok, net_force_req, out_valid} = '0;
        cmd_mode = fbsmc_pkg::FBSMC_CMD_IDLE;
        out_word = '0;
    end
    // Traffic stops on the clock after talk clears, so the station sees a real loss
    always @(posedge clk_sys) begin
        frame_ok <= talk;
    end
    // One-cycle mode command; mode field scrambled once released
    task automatic send_cmd(input fbsmc_pkg::fbsmc_cmd_e m);
        cmd_mode <= m;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_mode <= fbsmc_pkg::fbsmc_cmd_e'(~m);
    endtask
    // Configuration delivery, without which Idle refuses a Ready request
    task automatic send_cfg();
        cfg_valid <= 1'b1;
        @(posedge clk_sys);
        cfg_valid <= 1'b0;
    endtask
    // Force over the network, which Idle must refuse
    task automatic send_force();
        net_force_req <= 1'b1;
        @(posedge clk_sys);
        net_force_req <= 1'b0;
    endtask
    // Offer a word and hold it until the rising edge that samples ready high
    task automatic push_word(input logic [7:0] d, input logic q);
        out_word <= '{data: d, qual: q};
        out_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (out_ready !== 1'b1);
    endtask
    // Release the stream; data lines show junk afterwards
    task automatic idle_bus();
        out_valid <= 1'b0;
        out_word <= ~out_word;
    endtask
endmodule

/* sim/tb_fbsmc_station.sv */
// Self-checking testbench for the station mode controller
`timescale 1ns/1ps
module tb_fbsmc_station;
    logic clk_sys = 1'b0; // 25 MHz clock
    logic sys_rst = 1'b1; // Reset held at start
    logic [1:0] net_present, carrier_det, tx_active, led_carrier, led_tx;
    logic cfg_enable, hold_last, mod_ready, in_fault, out_ready, nv_load, mod_out_valid;
    logic [7:0] nv_default, nv_force_mask, nv_force_val, in_data, mod_out, in_tx_data;
    logic scan_en, in_qual, out_qual, io_exch_en, presence_en, handheld_mon_en, force_reject;
    logic fault_status, cfg_held, led_ok, led_run, cmd_valid, cfg_valid, frame_ok;
    logic net_force_req, out_valid;
    fbsmc_pkg::fbsmc_cmd_e cmd_mode;
    fbsmc_pkg::fbsmc_word_s out_word;
    fbsmc_pkg::fbsmc_mode_e mode;
    int fail_count = 0, tests_run = 0, nv_cnt = 0, rej_cnt = 0, run_cnt = 0, tog;
    logic [1:0] rdy_sel = 2'h0; // Modules ready: 0 stall, 1 always, 2 random
    logic [7:0] exp_q[$], got_q[$], d;
    always #20 clk_sys = ~clk_sys;
    fbsmc_station #(.COMM_TO_CYC(20), .DIAG_CYCLES(50), .BLINK_CYCLES(4)) dut (.*);
    fbsmc_net_model net (.*);
    // Output modules take words at the pace chosen by the test
    always @(posedge clk_sys) begin
        mod_ready <= (rdy_sel == 2'h1) || (rdy_sel == 2'h2 && $urandom_range(0, 1) == 1);
    end
    // Pulse and stream monitors
    always @(posedge clk_sys) begin
        if (mod_out_valid === 1'b1) got_q.push_back(mod_out);
        nv_cnt += int'(nv_load === 1'b1);
        rej_cnt += int'(force_reject === 1'b1);
        run_cnt += int'(led_run === 1'b1);
    end
    // Idle output: default merged with stored forces
    function automatic logic [7:0] idle_out(input logic [7:0] df, mk, fv);
        return (df & ~mk) | (fv & mk);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic summarize();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        step(5000);
        fail_count++;
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(22));
        {net_present, carrier_det, tx_active, cfg_enable, hold_last, in_fault} = '0;
        in_data = 8'($urandom);
        nv_default = 8'($urandom);
        nv_force_mask = 8'($urandom);
        nv_force_val = 8'($urandom);
        step(20);
        sys_rst <= 1'b0;
        tog = 0;
        for (int i = 0; i < 12; i++) begin
            d = {7'h00, led_ok};
            step(1);
            tog += int'(led_ok !== d[0]);
        end
        chk(32'(tog > 0), 1);
        chk(mode, fbsmc_pkg::FBSMC_IDLE);
        chk({in_qual, out_qual}, 2'h3);
        chk({scan_en, presence_en, io_exch_en, handheld_mon_en}, 4'hd);
        chk(nv_cnt, 1);
        chk(mod_out, idle_out(nv_default, nv_force_mask, nv_force_val));
        chk(in_tx_data, in_data);
        net.send_force();
        step(2);
        chk(rej_cnt, 1);
        net.send_cmd(fbsmc_pkg::FBSMC_CMD_RUN);
        step(1); // Strobe drops before the next command
        net.send_cmd(fbsmc_pkg::FBSMC_CMD_READY);
        step(3);
        chk(mode, fbsmc_pkg::FBSMC_IDLE);
        cfg_enable <= 1'b1;
        net.send_cfg();
        step(2);
        chk(cfg_held, 1);
        net.send_cmd(fbsmc_pkg::FBSMC_CMD_READY);
        step(3);
        chk(mode, fbsmc_pkg::FBSMC_IDLE);
        net_present <= 2'h1 << $urandom_range(0, 1);
        step(1);
        net.send_cmd(fbsmc_pkg::FBSMC_CMD_READY);
        step(3);
        chk(mode, fbsmc_pkg::FBSMC_READY);
        net.talk = 1'b1;
        net.send_cmd(fbsmc_pkg::FBSMC_CMD_RUN);
        step(2);
        chk({mode, io_exch_en}, {fbsmc_pkg::FBSMC_RUN, 1'b1});
        got_q.delete();
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            exp_q.push_back(d);
            net.push_word(d, 1'b0);
        end
        net.idle_bus();
        step(1);
        chk(out_ready, 0);
        rdy_sel <= 2'h2;
        for (int i = 0; i < 12; i++) begin
            d = (i == 5) ? 8'hff : (i == 6) ? 8'h00 : 8'($urandom);
            exp_q.push_back(d);
            net.push_word(d, 1'b0);
        end
        exp_q.push_back(nv_default);
        net.push_word(8'($urandom), 1'b1);
        net.idle_bus();
        rdy_sel <= 2'h1;
        step(6); // Two buffered words drain, then the monitor has seen both
        chk(out_qual, 1);
        chk(got_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
        chk(32'(run_cnt > 0), 1);
        in_fault <= 1'b1;
        step(3);
        chk({fault_status, mode}, {1'b1, fbsmc_pkg::FBSMC_RUN});
        in_fault <= 1'b0;
        step(3);
        chk(fault_status, 0);
        for (int i = 0; i < 4; i++) begin
            carrier_det <= 2'(i);
            tx_active <= 2'($urandom);
            step(3);
            chk(led_carrier, carrier_det);
            chk(led_tx, tx_active);
        end
        net.talk = 1'b0;
        step(24);
        chk(mode, fbsmc_pkg::FBSMC_READY);
        chk(led_ok, 1);
        net.send_cmd(fbsmc_pkg::FBSMC_CMD_IDLE);
        step(3);
        chk({mode, cfg_held, in_qual}, {fbsmc_pkg::FBSMC_IDLE, 2'h1});
        chk(nv_cnt, 2);
        hold_last <= 1'b1;
        step(3);
        chk(mod_out, idle_out(d, nv_force_mask, nv_force_val));
        summarize();
    end
endmodule
